// ==== inc/acs_pkg.sv ====
/*
 * Package for the converter input channel selection block: register indices,
 * field positions, reset values and code points.
 * Assumes a 16-bit register port with one-cycle read latency.
 */
package acs_pkg;

    // Register indices on the plain register port.
    localparam logic [2:0] ACS_REG_CH123 = 3'h0;
    localparam logic [2:0] ACS_REG_CH0 = 3'h1;
    localparam logic [2:0] ACS_REG_SCAN = 3'h2;
    localparam logic [2:0] ACS_REG_PCFG = 3'h3;
    localparam logic [2:0] ACS_REG_CTRL = 3'h4;
    localparam logic [2:0] ACS_REG_STAT = 3'h5;

    // Writable masks; every other bit is unimplemented and reads zero.
    localparam logic [15:0] ACS_MASK_CH123 = 16'h0707;
    localparam logic [15:0] ACS_MASK_CH0 = 16'h9F9F;
    localparam logic [15:0] ACS_MASK_SCAN = 16'h003F;
    localparam logic [15:0] ACS_MASK_PCFG = 16'h003F;
    localparam logic [15:0] ACS_MASK_CTRL = 16'h0007;

    // Reset value shared by every writable register.
    localparam logic [15:0] ACS_RESET_VALUE = 16'h0000;

    // Field positions.
    localparam int ACS_CH123_POS_A = 0;
    localparam int ACS_CH123_NEG_A_LO = 1;
    localparam int ACS_CH123_POS_B = 8;
    localparam int ACS_CH123_NEG_B_LO = 9;
    localparam int ACS_CH0_POS_A_LO = 0;
    localparam int ACS_CH0_NEG_A = 7;
    localparam int ACS_CH0_POS_B_LO = 8;
    localparam int ACS_CH0_NEG_B = 15;
    localparam int ACS_CTRL_RES = 0;
    localparam int ACS_CTRL_ALT = 1;
    localparam int ACS_CTRL_SCAN = 2;

    // Analog input counts of the two package variants, and the count of Sample B codes.
    localparam int ACS_SMALL_INPUTS = 4;
    localparam int ACS_LARGE_INPUTS = 6;
    localparam int ACS_CH0B_INPUTS = 10;

    // Multiplexer input codes.
    localparam logic [3:0] ACS_SEL_NEGREF = 4'hE;
    localparam logic [3:0] ACS_SEL_NONE = 4'hF;
    localparam logic [3:0] ACS_SEL_AN1 = 4'h1;

    // Sample phase of the alternate-sample sequence.
    typedef enum logic {ACS_PHASE_A, ACS_PHASE_B} acs_phase_t;

endpackage

// ==== inc/acs_sel_if.sv ====
/*
 * Interface carrying register contents from the register file to the
 * multiplexer decoder, and the decoded selects back. Assumes both ends share one clock.
 */
interface acs_sel_if;
    logic [15:0] ch123_reg;
    logic [15:0] ch0_reg;
    logic [5:0] scan_mask;
    logic [5:0] pin_digital_mode;
    logic resolution_mode;
    logic use_b;
    logic [3:0] scan_input;
    logic [3:0] ch0_pos;
    logic [3:0] ch0_neg;
    logic [3:0] ch1_pos;
    logic [3:0] ch2_pos;
    logic [3:0] ch3_pos;
    logic ch123_neg_ref;
    logic sel_reserved;
    logic [5:0] mux_to_ground;

    modport regs (output ch123_reg, ch0_reg, scan_mask, pin_digital_mode,
                  resolution_mode, use_b, scan_input,
                  input ch0_pos, ch0_neg, ch1_pos, ch2_pos, ch3_pos, ch123_neg_ref,
                  sel_reserved, mux_to_ground);
    modport dec (input ch123_reg, ch0_reg, scan_mask, pin_digital_mode,
                 resolution_mode, use_b, scan_input,
                 output ch0_pos, ch0_neg, ch1_pos, ch2_pos, ch3_pos, ch123_neg_ref,
                 sel_reserved, mux_to_ground);
endinterface

// ==== core/acs_decode.sv ====
/*
 * Combinational decoder from register contents to multiplexer selects.
 * Assumes the register file drives the interface from flip-flops.
 */
module acs_decode
    import acs_pkg::*;
#(
    parameter int LARGE_VARIANT = 1
) (
    acs_sel_if.dec sel
);
    localparam int N_IN = LARGE_VARIANT != 0 ? ACS_LARGE_INPUTS : ACS_SMALL_INPUTS;

    // Routes a code to its input when it is in range, otherwise disconnects.
    function automatic logic [3:0] acs_route(input logic [4:0] code, input int limit);
        acs_route = (int'(code) < limit) ? code[3:0] : ACS_SEL_NONE;
    endfunction

    wire pos123 = sel.use_b ? sel.ch123_reg[ACS_CH123_POS_B] : sel.ch123_reg[ACS_CH123_POS_A];
    wire [1:0] neg123 = sel.use_b ? sel.ch123_reg[ACS_CH123_NEG_B_LO +: 2]
                                  : sel.ch123_reg[ACS_CH123_NEG_A_LO +: 2];
    wire [4:0] pos0_a = sel.ch0_reg[ACS_CH0_POS_A_LO +: 5];
    wire [4:0] pos0_b = sel.ch0_reg[ACS_CH0_POS_B_LO +: 5];
    wire neg0 = sel.use_b ? sel.ch0_reg[ACS_CH0_NEG_B] : sel.ch0_reg[ACS_CH0_NEG_A];
    wire ten_bit = !sel.resolution_mode;

    // Channel 1-3 positive routing; on select 1 the smaller package leaves 2 and 3 open.
    wire [3:0] c1 = pos123 ? 4'h3 : 4'h0;
    wire [3:0] c2 = pos123 ? ((LARGE_VARIANT != 0) ? 4'h4 : ACS_SEL_NONE) : 4'h1;
    wire [3:0] c3 = pos123 ? ((LARGE_VARIANT != 0) ? 4'h5 : ACS_SEL_NONE) : 4'h2;

    // Channels 1-3 only exist in the 10-bit mode; in 12-bit every code is reserved.
    assign sel.ch1_pos = ten_bit ? c1 : ACS_SEL_NONE;
    assign sel.ch2_pos = ten_bit ? c2 : ACS_SEL_NONE;
    assign sel.ch3_pos = ten_bit ? c3 : ACS_SEL_NONE;
    assign sel.ch123_neg_ref = ten_bit && !neg123[1];
    assign sel.sel_reserved = !ten_bit || neg123[1];

    // Channel 0: scanning overrides Sample A only; Sample B has ten codes.
    wire [3:0] pos0_sel_a = acs_route(pos0_a, N_IN);
    wire [3:0] pos0_sel_b = acs_route(pos0_b, ACS_CH0B_INPUTS);
    assign sel.ch0_pos = sel.use_b ? pos0_sel_b : sel.scan_input;
    assign sel.ch0_neg = neg0 ? ACS_SEL_AN1 : ACS_SEL_NEGREF;

    // Digital pins tie their mux input to ground; absent pins have no effect.
    genvar g;
    for (g = 0; g < 6; g++) begin : g_pin
        assign sel.mux_to_ground[g] = (g < N_IN) && sel.pin_digital_mode[g];
    end

    // Unused locally: Sample A code when not scanning is chosen in the top.
    wire unused_a = ^pos0_sel_a;
endmodule

// ==== core/acs_channel_select.sv ====
/*
 * Input channel selection for a multi-channel converter: select, scan and
 * port configuration registers on a plain register port, with decoded
 * multiplexer and pin buffer controls.
 * Assumes synchronous inputs and a master that never overlaps strobes.
 */
// Design decisions made here: the plain strobed port and the placing of the registers.
// Functional notes
// - Small variant select 1 routes AN3 only
// - Large variant select 1 routes AN3, AN4, AN5
// - Ch1-3 negative 00/01 reference, others reserved
// - Unimplemented bits ignore writes, read zero
// - Ch0 Sample B negative: AN1 or reference
// - Ch0 Sample A negative: AN1 or reference
// - Ch0 Sample B positive codes zero to nine
// - Small variant Sample A codes zero to three
// - Large variant Sample A codes zero to five
// - Scan bits include or skip each input
// - Scan absent input converts negative reference
// - Set pin bit: digital, read enabled, grounded
// - Clear pin bit: analog, read disabled
// - All pin bits writable, absent pins ignored; only mux_to_ground ignores them, port_read_enable follows absent pin bits
// - Resolution bit selects 12-bit or 10-bit
// - Scan enable steps channel 0 through mask
// - Alternate sample swaps A and B selects
module acs_channel_select
    import acs_pkg::*;
#(
    parameter int LARGE_VARIANT = 1
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register port.
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    // Converter sequencing: one pulse per finished sample.
    input wire logic sample_done,
    // Multiplexer selects.
    output logic [3:0] ch0_pos_input,
    output logic [3:0] ch0_neg_input,
    output logic [3:0] ch1_pos_input,
    output logic [3:0] ch2_pos_input,
    output logic [3:0] ch3_pos_input,
    output logic ch123_neg_is_ref,
    output logic select_reserved,
    output logic resolution_mode,
    // Pin controls.
    output logic [5:0] port_read_enable,
    output logic [5:0] mux_to_ground
);
    localparam int N_IN = LARGE_VARIANT != 0 ? ACS_LARGE_INPUTS : ACS_SMALL_INPUTS;

    acs_sel_if sel ();

    logic [15:0] ch123_reg;
    logic [15:0] ch0_reg;
    logic [5:0] scan_mask;
    logic [5:0] pin_digital_mode;
    logic [2:0] ctrl;
    acs_phase_t phase;
    logic [2:0] scan_idx;

    // Write decode; masks drop every unimplemented bit.
    wire wr_ch123 = reg_write && reg_addr == ACS_REG_CH123;
    wire wr_ch0 = reg_write && reg_addr == ACS_REG_CH0;
    wire wr_scan = reg_write && reg_addr == ACS_REG_SCAN;
    wire wr_pcfg = reg_write && reg_addr == ACS_REG_PCFG;
    wire wr_ctrl = reg_write && reg_addr == ACS_REG_CTRL;
    wire alt_on = ctrl[ACS_CTRL_ALT];
    wire scan_on = ctrl[ACS_CTRL_SCAN];

    // Next scan position: first set mask bit after the current one, wrapping.
    function automatic logic [2:0] acs_next_scan(input logic [5:0] mask, input logic [2:0] cur);
        logic [2:0] r;
        logic [2:0] k;
        r = cur;
        for (int i = 6; i >= 1; i--) begin
            k = 3'((int'(cur) + i) % 6);
            if (mask[k]) begin
                r = k;
            end
        end
        return r;
    endfunction

    wire [2:0] next_scan_idx = acs_next_scan(scan_mask, scan_idx);
    wire scan_present = int'(scan_idx) < N_IN;
    // Absent scanned positions convert the negative reference.
    wire [3:0] scan_input = scan_present ? {1'b0, scan_idx} : ACS_SEL_NEGREF;
    wire [3:0] a_direct = (int'(ch0_reg[4:0]) < N_IN) ? ch0_reg[3:0] : ACS_SEL_NONE;

    // Register file; all writable bits clear at reset.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch123_reg <= ACS_RESET_VALUE;
            ch0_reg <= ACS_RESET_VALUE;
            scan_mask <= '0;
            pin_digital_mode <= '0;
            ctrl <= '0;
        end else begin
            if (wr_ch123) ch123_reg <= reg_wdata & ACS_MASK_CH123;
            if (wr_ch0) ch0_reg <= reg_wdata & ACS_MASK_CH0;
            if (wr_scan) scan_mask <= reg_wdata[5:0];
            if (wr_pcfg) pin_digital_mode <= reg_wdata[5:0];
            if (wr_ctrl) ctrl <= reg_wdata[2:0];
        end
    end

    // Sample phase advances on each finished sample, scan position on each one ending in phase A. Turning
    // alternate sampling off parks the phase at A, so a later scan is not held
    // back by a stale Sample B phase.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= ACS_PHASE_A;
            scan_idx <= '0;
        end else if (sample_done) begin
            phase <= (alt_on && phase == ACS_PHASE_A) ? ACS_PHASE_B : ACS_PHASE_A;
            if (scan_on && phase == ACS_PHASE_A) scan_idx <= next_scan_idx;
        end else begin
            if (!alt_on) phase <= ACS_PHASE_A;
            if (!scan_on) scan_idx <= acs_next_scan(scan_mask, 3'h5);
        end
    end

    assign sel.ch123_reg = ch123_reg;
    assign sel.ch0_reg = ch0_reg;
    assign sel.scan_mask = scan_mask;
    assign sel.pin_digital_mode = pin_digital_mode;
    assign sel.resolution_mode = ctrl[ACS_CTRL_RES];
    assign sel.use_b = alt_on && phase == ACS_PHASE_B;
    assign sel.scan_input = scan_on ? scan_input : a_direct;

    acs_decode #(.LARGE_VARIANT(LARGE_VARIANT)) u_decode (.sel(sel));

    // Read mux; unmapped addresses read zero.
    wire [15:0] stat_word = {12'h000, select_reserved, scan_idx};
    wire [15:0] rd_word =
        reg_addr == ACS_REG_CH123 ? ch123_reg :
        reg_addr == ACS_REG_CH0 ? ch0_reg :
        reg_addr == ACS_REG_SCAN ? {10'h000, scan_mask} :
        reg_addr == ACS_REG_PCFG ? {10'h000, pin_digital_mode} :
        reg_addr == ACS_REG_CTRL ? {13'h0000, ctrl} :
        reg_addr == ACS_REG_STAT ? stat_word : 16'h0000;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_read ? rd_word : 16'h0000;
        end
    end

    // Outputs are registered copies of the decode; the decode itself sees the
    // registers directly, so a write shows one edge after it lands.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch0_pos_input <= 4'h0;
            ch0_neg_input <= ACS_SEL_NEGREF;
            ch1_pos_input <= ACS_SEL_NONE;
            ch2_pos_input <= ACS_SEL_NONE;
            ch3_pos_input <= ACS_SEL_NONE;
            ch123_neg_is_ref <= 1'b0;
            select_reserved <= 1'b0;
            resolution_mode <= 1'b0;
            port_read_enable <= '0;
            mux_to_ground <= '0;
        end else begin
            ch0_pos_input <= sel.ch0_pos;
            ch0_neg_input <= sel.ch0_neg;
            ch1_pos_input <= sel.ch1_pos;
            ch2_pos_input <= sel.ch2_pos;
            ch3_pos_input <= sel.ch3_pos;
            ch123_neg_is_ref <= sel.ch123_neg_ref;
            select_reserved <= sel.sel_reserved;
            resolution_mode <= sel.resolution_mode;
            port_read_enable <= pin_digital_mode;
            mux_to_ground <= sel.mux_to_ground;
        end
    end

    // Assertions.
    a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
        reg_write && reg_addr == ACS_REG_CH0 |=> (ch0_reg & ~ACS_MASK_CH0) == 16'h0000)
        else $error("Unimplemented channel 0 bits were stored.");
    a_neg0_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !alt_on && ch0_reg[ACS_CH0_NEG_A] |=> ch0_neg_input == ACS_SEL_AN1)
        else $error("Channel 0 negative did not follow Sample A bit.");
    a_neg0b_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
        sel.use_b && !ch0_reg[ACS_CH0_NEG_B] |=> ch0_neg_input == ACS_SEL_NEGREF)
        else $error("Channel 0 Sample B negative not reference.");
    a_ch1_route: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !ctrl[ACS_CTRL_RES] && !alt_on && ch123_reg[0] |=> ch1_pos_input == 4'h3)
        else $error("Channel 1 did not route input 3.");
    a_twelve_res: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ctrl[ACS_CTRL_RES] |=> select_reserved && ch1_pos_input == ACS_SEL_NONE)
        else $error("Channel 1 routed in 12-bit mode.");
    a_pin_digital: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_pcfg && reg_wdata[0] |=> ##1 port_read_enable[0] && mux_to_ground[0])
        else $error("Digital pin did not enable read and ground.");
    a_pin_analog: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_pcfg && !reg_wdata[1] |=> ##1 !port_read_enable[1])
        else $error("Analog pin left read enabled.");
    a_alt_phase: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !alt_on |-> phase == ACS_PHASE_A || $past(alt_on))
        else $error("Phase B reached without alternate sampling.");
    a_scan_mask: assert property (@(posedge ref_clk) disable iff (!reset_n)
        scan_on && sample_done && phase == ACS_PHASE_A && |scan_mask |=> scan_mask[scan_idx])
        else $error("Scan stepped to an unmarked input.");
endmodule

// ==== tb/acs_sample_model.sv ====
/*
 * Behavioural model of the converter sequencer that reports finished samples.
 * Assumes one clock shared with the selection block and an active-low reset.
 */
module acs_sample_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Request for one sample and its length in extra cycles.
    input wire logic start,
    input wire logic [3:0] hold_cycles,
    // One-cycle pulse when the sample is finished.
    output logic sample_done
);
    logic [4:0] count;

    // A count of zero means idle, so the done pulse is never repeated.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 5'h00;
            sample_done <= 1'b0;
        end else begin
            sample_done <= (count == 5'h01);
            if (start) begin
                count <= {1'b0, hold_cycles} + 5'h01;
            end else if (count != 5'h00) begin
                count <= count - 5'h01;
            end
        end
    end
endmodule

// ==== tb/tb_acs_channel_select.sv ====
/*
 * Self-checking bench for the input channel selection block, large variant.
 * Assumes the register port contract of the block and the sample model beside it.
 */
module tb_acs_channel_select;
    import acs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic sample_done, start = 1'b0;
    logic [3:0] hold_cycles = 4'h0;
    logic [3:0] ch0_pos_input, ch0_neg_input, ch1_pos_input, ch2_pos_input, ch3_pos_input;
    logic ch123_neg_is_ref, select_reserved, resolution_mode;
    logic [5:0] port_read_enable, mux_to_ground;
    int n_fail = 0;
    int comparisons = 0;
    logic [15:0] masks [8] = '{ACS_MASK_CH123, ACS_MASK_CH0, ACS_MASK_SCAN, ACS_MASK_PCFG,
                                ACS_MASK_CTRL, 16'h0000, 16'h0000, 16'h0000};

    always #50 ref_clk = ~ref_clk;

    acs_channel_select #(.LARGE_VARIANT(1)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_done(sample_done),
        .ch0_pos_input(ch0_pos_input), .ch0_neg_input(ch0_neg_input),
        .ch1_pos_input(ch1_pos_input), .ch2_pos_input(ch2_pos_input),
        .ch3_pos_input(ch3_pos_input), .ch123_neg_is_ref(ch123_neg_is_ref),
        .select_reserved(select_reserved), .resolution_mode(resolution_mode),
        .port_read_enable(port_read_enable), .mux_to_ground(mux_to_ground));

    acs_sample_model partner (.ref_clk(ref_clk), .reset_n(reset_n), .start(start),
        .hold_cycles(hold_cycles), .sample_done(sample_done));

    // Channel 0 Sample A codes above the last present input leave it unconnected.
    function automatic logic [3:0] exp_ch0a(input logic [4:0] code);
        return (code < 5'h06) ? code[3:0] : ACS_SEL_NONE;
    endfunction

    // The two negative choices of channel 0 share one coding.
    function automatic logic [3:0] exp_neg(input logic bit_set);
        return bit_set ? ACS_SEL_AN1 : ACS_SEL_NEGREF;
    endfunction

    task automatic close_out();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Strobes are raised just after an edge and dropped after the sampling edge.
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look at mid-cycle.
    task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        @(negedge ref_clk);
        chk("reg_rdata", exp, reg_rdata);
    endtask

    // Decoded outputs lag the register by one stage.
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // One sample with a random length; a missing done pulse ends the run.
    task automatic one_sample();
        int i;
        @(posedge ref_clk);
        start <= 1'b1;
        hold_cycles <= 4'($urandom_range(0, 7));
        @(posedge ref_clk);
        start <= 1'b0;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (sample_done === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            close_out();
        end
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    initial begin
        logic [15:0] w;
        logic [2:0] c;
        void'($urandom(48));
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle();
        // Everything clears at reset and the 10-bit defaults decode one edge after release.
        for (int a = 0; a < 8; a++) if (a != 5) rchk(3'(a), ACS_RESET_VALUE);
        chk("ch1..3", 16'h0012, {4'h0, ch1_pos_input, ch2_pos_input, ch3_pos_input});
        chk("ch0", {8'h00, 4'h0, ACS_SEL_NEGREF}, {8'h00, ch0_pos_input, ch0_neg_input});
        // Random words keep only the implemented bits; unmapped places read zero.
        for (int n = 0; n < 24; n++) begin
            c = 3'($urandom_range(0, 7));
            if (c == 3'h5) continue;
            w = 16'($urandom());
            wr(c, w);
            rchk(c, w & masks[c]);
        end
        // Pin configuration reaches both pin controls on every pin.
        for (int n = 0; n < 6; n++) begin
            w = 16'($urandom());
            wr(ACS_REG_PCFG, w);
            settle();
            chk("port_read_enable", {10'h000, w[5:0]}, {10'h000, port_read_enable});
            chk("mux_to_ground", {10'h000, w[5:0]}, {10'h000, mux_to_ground});
        end
        // Channel 1-3 selects over both modes and all negative codes.
        for (int m = 0; m < 16; m++) begin
            wr(ACS_REG_CTRL, {15'h0000, m[3]});
            wr(ACS_REG_CH123, {13'h0000, m[2:0]});
            settle();
            chk("resolution_mode", {15'h0000, m[3]}, {15'h0000, resolution_mode});
            chk("select_reserved", {15'h0000, m[3] | m[2]}, {15'h0000, select_reserved});
            if (m[3] == 1'b0) begin
                chk("neg_is_ref", {15'h0000, ~m[2]}, {15'h0000, ch123_neg_is_ref});
                chk("ch1..3", m[0] ? 16'h0345 : 16'h0012,
                    {4'h0, ch1_pos_input, ch2_pos_input, ch3_pos_input});
            end
        end
        // Channel 0 Sample A codes, valid and out of range, with a random negative.
        wr(ACS_REG_CTRL, 16'h0000);
        for (int k = 0; k < 32; k++) begin
            w = {8'($urandom()), 1'($urandom()), 2'b00, 5'(k)};
            wr(ACS_REG_CH0, w);
            settle();
            chk("ch0_pos", {12'h000, exp_ch0a(w[4:0])}, {12'h000, ch0_pos_input});
            chk("ch0_neg", {12'h000, exp_neg(w[7])}, {12'h000, ch0_neg_input});
        end
        // Alternate sampling swaps to the Sample B selects and back.
        wr(ACS_REG_CH0, 16'h8903);
        wr(ACS_REG_CTRL, 16'h0002);
        for (int s = 0; s < 4; s++) begin
            if (s > 0) one_sample();
            else settle();
            chk("alt ch0_pos", s[0] ? 16'h0009 : 16'h0003, {12'h000, ch0_pos_input});
            chk("alt ch0_neg", {12'h000, exp_neg(s[0])}, {12'h000, ch0_neg_input});
        end
        // Scanning visits only the inputs set in the mask, wrapping round.
        wr(ACS_REG_SCAN, 16'h0025);
        wr(ACS_REG_CTRL, 16'h0004);
        settle();
        for (int s = 0; s < 7; s++) begin
            chk("scan ch0_pos", {12'h000, 4'(s % 3 == 0 ? 0 : s % 3 == 1 ? 2 : 5)},
                {12'h000, ch0_pos_input});
            one_sample();
        end
        close_out();
    end
endmodule
